//--- rtl/sss_engine.v
// sequencing state engine: state memory, exit detectors, fault latch, drivers
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "sss_defines.vh"
module sss_engine #(
  parameter TO_STEP_CYC = `SSS_TO_STEP_NS / `SSS_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_n_in,
  // register port
  input  wire [7:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [31:0] reg_rdata_out,
  // supply fault detector results, sfd_ok_in high means okay, uv/ov/lim high on a trip
  input  wire [9:0]  sfd_ok_in,
  input  wire [9:0]  uv_in,
  input  wire [9:0]  ov_in,
  input  wire [9:0]  lim_in,
  // warnings and digital inputs
  input  wire        adc_limit_warn_in,
  input  wire        secondary_warn_in,
  input  wire [4:0]  dual_function_input_in,
  // driver levels and engine state
  output reg  [9:0]  programmable_driver_output_out,
  output reg  [5:0]  state_out
);
  localparam SEQ_STEP_CYC = `SSS_SEQ_STEP_NS / `SSS_CLK_PERIOD_NS;
  localparam CLK_HALF_CYC = `SSS_CLK100K_HALF_NS / `SSS_CLK_PERIOD_NS;
  localparam PH_IDLE = 2'h0;
  localparam PH_LOAD = 2'h1;
  localparam PH_CAPT = 2'h2;
  localparam PH_RUN  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [1:0]             phase_reg;
  reg  [1:0]             phase_next;
  reg  [5:0]             rd_addr_reg;
  reg  [5:0]             rd_addr_next;
  reg  [`SSS_DEF_W-1:0]  def_reg;
  reg                    jump_reg;
  reg                    start_reg;
  reg  [9:0]             fault_reg;
  reg  [19:0]            drv_src_reg;
  reg  [9:0]             drv_bus_reg;
  reg  [4:0]             dig_en_reg;
  reg  [31:0]            def_w0_reg;
  reg  [31:0]            def_w1_reg;
  reg  [15:0]            def_w2_reg;
  reg  [5:0]             def_addr_reg;
  reg                    mem_wr_reg;
  reg  [15:0]            seq_pre_reg;
  reg  [15:0]            to_pre_reg;
  reg  [15:0]            clk_pre_reg;
  reg                    clk100k_reg;
  reg  [31:0]            rdata_next;
  wire [`SSS_DEF_W-1:0]  mem_rdata;
  wire [15:0]            eng_in;
  wire                   warn;
  wire                   seq_met;
  wire                   seq_done;
  wire                   to_done;
  wire                   mon_fire;
  wire                   seq_exit;
  wire                   to_exit;
  wire                   running;
  wire                   seq_step;
  wire                   to_step;
  wire [9:0]             new_fault;
  wire                   wr_cmd;
  wire [9:0]             flt_clr;

  ////////////////////////////////////////////////////////////////////////////
  // definition fields and engine inputs
  wire [9:0]  f_drv  = def_reg[`SSS_F_DRV_HI:`SSS_F_DRV_LO];
  wire [4:0]  f_ssel = def_reg[`SSS_F_SSEL_HI:`SSS_F_SSEL_LO];
  wire        f_slvl = def_reg[`SSS_F_SLVL];
  wire [15:0] f_sdly = def_reg[`SSS_F_SDLY_HI:`SSS_F_SDLY_LO];
  wire [11:0] f_to   = def_reg[`SSS_F_TO_HI:`SSS_F_TO_LO];
  wire [15:0] f_mmsk = def_reg[`SSS_F_MMSK_HI:`SSS_F_MMSK_LO];
  wire        f_lat  = def_reg[`SSS_F_LATCH];
  wire        f_mpol = def_reg[`SSS_F_MPOL];
  wire [5:0]  f_nseq = def_reg[`SSS_F_NSEQ_HI:`SSS_F_NSEQ_LO];
  wire [5:0]  f_nmon = def_reg[`SSS_F_NMON_HI:`SSS_F_NMON_LO];
  wire [5:0]  f_nto  = def_reg[`SSS_F_NTO_HI:`SSS_F_NTO_LO];

  // one warning bit for both warning sources
  assign warn    = adc_limit_warn_in | secondary_warn_in;
  // inputs 0..9 supplies, 10..14 digital pins when enabled, 15 warning
  assign eng_in  = {warn, dual_function_input_in & dig_en_reg, sfd_ok_in};
  assign running = (phase_reg == PH_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // step prescalers, restarted on every state entry; the sequence one also on any
  // drop, so a qualifying delay never finishes early on a partial first step
  assign seq_step = (seq_pre_reg == SEQ_STEP_CYC[15:0] - 16'h0001);
  assign to_step  = (to_pre_reg == TO_STEP_CYC[15:0] - 16'h0001);

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_pre_reg <= 16'h0000;
      to_pre_reg  <= 16'h0000;
    end else if (!running) begin
      seq_pre_reg <= 16'h0000;
      to_pre_reg  <= 16'h0000;
    end else begin
      seq_pre_reg <= (seq_step | ~seq_met) ? 16'h0000 : seq_pre_reg + 16'h0001;
      to_pre_reg  <= to_step ? 16'h0000 : to_pre_reg + 16'h0001;
    end
  end

  // free-running half period counter for the 100 kHz driver clock
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_pre_reg <= 16'h0000;
      clk100k_reg <= 1'b0;
    end else if (clk_pre_reg == CLK_HALF_CYC[15:0] - 16'h0001) begin
      clk_pre_reg <= 16'h0000;
      clk100k_reg <= ~clk100k_reg;
    end else begin
      clk_pre_reg <= clk_pre_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exit detectors
  assign seq_met = (eng_in[f_ssel[3:0]] == f_slvl) & ~f_ssel[4];

  // any drop of the watched condition clears the qualifying delay
  sss_timer u_seq_timer (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .clear_in   (~running | ~seq_met),
    .step_in    (seq_step),
    .limit_in   (f_sdly),
    .done_out   (seq_done)
  );

  // timeout counts from state entry regardless of inputs
  sss_timer u_to_timer (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .clear_in   (~running),
    .step_in    (to_step),
    .limit_in   ({4'h0, f_to}),
    .done_out   (to_done)
  );

  // wide OR of masked deviations, no filtering at all
  assign mon_fire = |(f_mmsk & ~(eng_in ^ {16{f_mpol}}));
  assign seq_exit = (seq_met & seq_done) | jump_reg;
  // zero timeout field means the route is unused
  assign to_exit  = (f_to != 12'h000) & to_done & ~seq_met;

  ////////////////////////////////////////////////////////////////////////////
  // engine sequencer
  always @* begin
    phase_next   = phase_reg;
    rd_addr_next = rd_addr_reg;
    case (phase_reg)
      PH_IDLE: begin
        if (start_reg) begin
          rd_addr_next = 6'h00;
          phase_next   = PH_LOAD;
        end
      end
      PH_LOAD: begin
        phase_next = PH_CAPT; // memory read data lands this edge
      end
      PH_CAPT: begin
        phase_next = PH_RUN;
      end
      PH_RUN: begin
        // fixed priority when routes coincide
        if (mon_fire) begin
          rd_addr_next = f_nmon;
          phase_next   = PH_LOAD;
        end else if (to_exit) begin
          rd_addr_next = f_nto;
          phase_next   = PH_LOAD;
        end else if (seq_exit) begin
          rd_addr_next = f_nseq;
          phase_next   = PH_LOAD;
        end
      end
      default: begin
        phase_next = PH_IDLE;
      end
    endcase
  end

  // three clocks per state change, far below the 20 us budget
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg   <= PH_IDLE;
      rd_addr_reg <= 6'h00;
      def_reg     <= {`SSS_DEF_W{1'b0}};
      state_out   <= 6'h00;
    end else begin
      phase_reg   <= phase_next;
      rd_addr_reg <= rd_addr_next;
      if (phase_reg == PH_CAPT) begin
        def_reg   <= mem_rdata;
        state_out <= rd_addr_reg;
      end
    end
  end

  sss_state_mem u_mem (
    .sys_clk_in  (sys_clk_in),
    .wr_en_in    (mem_wr_reg),
    .wr_addr_in  (def_addr_reg),
    .wr_data_in  ({def_w2_reg, def_w1_reg, def_w0_reg}),
    .rd_addr_in  (rd_addr_reg),
    .rd_data_out (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // driver outputs, taken with the definition so they change together with state_out
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_drv
      always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          programmable_driver_output_out[gi] <= 1'b0;
        end else begin
          case (drv_src_reg[2*gi+1:2*gi])
            `SSS_SRC_BUS: programmable_driver_output_out[gi] <= drv_bus_reg[gi];
            `SSS_SRC_CLK: programmable_driver_output_out[gi] <= clk100k_reg;
            default:      programmable_driver_output_out[gi] <= (phase_reg == PH_CAPT) ? mem_rdata[gi] : f_drv[gi];
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // fault latch: hardware set beats a software clear in the same cycle
  assign new_fault = (running & f_lat) ? (f_mmsk[9:0] & ~sfd_ok_in) : 10'h000;
  assign wr_cmd    = reg_wr_in & (reg_addr_in == `SSS_OFS_CMD);
  assign flt_clr   = {reg_wr_in & (reg_addr_in == `SSS_OFS_FLT_HI) ? reg_wdata_in[4:0] : 5'h00,
                      reg_wr_in & (reg_addr_in == `SSS_OFS_FLT_LO) ? reg_wdata_in[4:0] : 5'h00};

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_reg <= 10'h000;
    end else begin
      fault_reg <= (fault_reg & ~flt_clr) | new_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      jump_reg     <= 1'b0;
      start_reg    <= 1'b0;
      drv_src_reg  <= 20'h00000;
      drv_bus_reg  <= 10'h000;
      dig_en_reg   <= 5'h00;
      def_w0_reg   <= 32'h00000000;
      def_w1_reg   <= 32'h00000000;
      def_w2_reg   <= 16'h0000;
      def_addr_reg <= 6'h00;
      mem_wr_reg   <= 1'b0;
    end else begin
      mem_wr_reg <= 1'b0;
      // a jump waits until the engine is running with no monitor or timeout exit, then is consumed
      if (wr_cmd && reg_wdata_in[`SSS_CMD_JUMP]) begin
        jump_reg <= 1'b1;
      end else if (running && !mon_fire && !to_exit) begin
        jump_reg <= 1'b0;
      end
      start_reg <= wr_cmd & reg_wdata_in[`SSS_CMD_START];
      if (reg_wr_in) begin
        case (reg_addr_in)
          `SSS_OFS_DRV_SRC:  drv_src_reg <= reg_wdata_in[19:0];
          `SSS_OFS_DRV_BUS:  drv_bus_reg <= reg_wdata_in[9:0];
          `SSS_OFS_DIG_EN:   dig_en_reg  <= reg_wdata_in[4:0];
          `SSS_OFS_DEF_W0:   def_w0_reg  <= reg_wdata_in;
          `SSS_OFS_DEF_W1:   def_w1_reg  <= reg_wdata_in;
          `SSS_OFS_DEF_W2:   def_w2_reg  <= reg_wdata_in[15:0];
          `SSS_OFS_DEF_ADDR: begin
            def_addr_reg <= reg_wdata_in[5:0];
            mem_wr_reg   <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, data stand in the cycle after the strobe
  always @* begin
    rdata_next = 32'h00000000;
    case (reg_addr_in)
      `SSS_OFS_CMD:      rdata_next = {30'h00000000, running, jump_reg};
      `SSS_OFS_STATE:    rdata_next = {24'h000000, phase_reg, state_out};
      `SSS_OFS_FLT_LO:   rdata_next = {27'h0000000, fault_reg[4:0]};
      `SSS_OFS_FLT_HI:   rdata_next = {27'h0000000, fault_reg[9:5]};
      `SSS_OFS_UV:       rdata_next = {22'h000000, uv_in};
      `SSS_OFS_OV:       rdata_next = {22'h000000, ov_in};
      `SSS_OFS_LIM:      rdata_next = {22'h000000, lim_in};
      `SSS_OFS_DRV_SRC:  rdata_next = {12'h000, drv_src_reg};
      `SSS_OFS_DRV_BUS:  rdata_next = {22'h000000, drv_bus_reg};
      `SSS_OFS_DIG_EN:   rdata_next = {27'h0000000, dig_en_reg};
      `SSS_OFS_DEF_W0:   rdata_next = def_w0_reg;
      `SSS_OFS_DEF_W1:   rdata_next = def_w1_reg;
      `SSS_OFS_DEF_W2:   rdata_next = {16'h0000, def_w2_reg};
      `SSS_OFS_DEF_ADDR: rdata_next = {26'h0000000, def_addr_reg};
      default:           rdata_next = 32'h00000000;
    endcase
  end

  // read data hold zero except in the cycle after a read strobe
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata_next : 32'h00000000;
    end
  end
endmodule // sss_engine

//--- include/sss_defines.vh
// constants for the supply sequencing state engine
// How it works
// - state memory holds 63 definitions: outputs, exits, timers and targets
// - every state watches the okay signals of all ten supply inputs
// - each target field may name any of the 63 states
// - three exits per state: sequence, monitor, timeout, each with own target
// - sequence delay and timeout reload from each new definition, up to 400 ms
// - driver levels come from the definition at entry and hold in the state
// - a state change, definition load included, finishes well under 20 us
// - converter limit and secondary monitor warnings are ORed into one input
// - a bus jump command forces the sequence exit of the current state; here a monitor or timeout exit wins and the jump carries to the next state
// - sequence detector watches one selected input for its target level
// - sequence qualifying delay counts in 10 us steps up to 400 ms
// - watched input must hold for the whole delay; a change restarts it
// - monitor ORs masked inputs and fires when any leaves expected level
// - monitor has no delay; only the definition load latency applies
// - timeout exit when sequence unmet at end of 100 us..400 ms timeout
// - fault latch keeps one sticky bit per supply input
// - host reads the fault latch over the register port
// - per-state latch enable; while off no new bits set, old bits kept
// - undervoltage, overvoltage and limit status read live, never latched
// - each driver picks engine level, bus bit, or 100 kHz clock
// - digital inputs, when enabled as such, are engine inputs
`ifndef SSS_DEFINES_VH
`define SSS_DEFINES_VH
// timing
`define SSS_CLK_PERIOD_NS   8
`define SSS_SEQ_STEP_NS     10000
`define SSS_TO_STEP_NS      100000
`define SSS_CLK100K_HALF_NS 5000
// memory geometry
`define SSS_NUM_STATES      63
`define SSS_DEF_W           80
// register byte offsets
`define SSS_OFS_CMD         8'h00
`define SSS_OFS_STATE       8'h04
`define SSS_OFS_FLT_LO      8'h08
`define SSS_OFS_FLT_HI      8'h0c
`define SSS_OFS_UV          8'h10
`define SSS_OFS_OV          8'h14
`define SSS_OFS_LIM         8'h18
`define SSS_OFS_DRV_SRC     8'h1c
`define SSS_OFS_DRV_BUS     8'h20
`define SSS_OFS_DIG_EN      8'h24
`define SSS_OFS_DEF_W0      8'h28
`define SSS_OFS_DEF_W1      8'h2c
`define SSS_OFS_DEF_W2      8'h30
`define SSS_OFS_DEF_ADDR    8'h34
// command bits
`define SSS_CMD_JUMP        0
`define SSS_CMD_START       1
// definition word fields
`define SSS_F_DRV_LO        0
`define SSS_F_DRV_HI        9
`define SSS_F_SSEL_LO       10
`define SSS_F_SSEL_HI       14
`define SSS_F_SLVL          15
`define SSS_F_SDLY_LO       16
`define SSS_F_SDLY_HI       31
`define SSS_F_TO_LO         32
`define SSS_F_TO_HI         43
`define SSS_F_MMSK_LO       44
`define SSS_F_MMSK_HI       59
`define SSS_F_LATCH         60
`define SSS_F_MPOL          61
`define SSS_F_NSEQ_LO       62
`define SSS_F_NSEQ_HI       67
`define SSS_F_NMON_LO       68
`define SSS_F_NMON_HI       73
`define SSS_F_NTO_LO        74
`define SSS_F_NTO_HI        79
// driver source codes
`define SSS_SRC_ENGINE      2'h0
`define SSS_SRC_BUS         2'h1
`define SSS_SRC_CLK         2'h2
`endif

//--- rtl/sss_state_mem.v
// state definition memory with registered read data
`timescale 1ns/100ps
`include "sss_defines.vh"
module sss_state_mem (
  // clock
  input  wire                      sys_clk_in,
  // write port
  input  wire                      wr_en_in,
  input  wire [5:0]                wr_addr_in,
  input  wire [`SSS_DEF_W-1:0]     wr_data_in,
  // read port
  input  wire [5:0]                rd_addr_in,
  output reg  [`SSS_DEF_W-1:0]     rd_data_out
);
  reg [`SSS_DEF_W-1:0] mem_reg [0:`SSS_NUM_STATES-1];

  // entry 63 does not exist: writes drop, reads give zero
  always @(posedge sys_clk_in) begin
    if (wr_en_in && (wr_addr_in < `SSS_NUM_STATES)) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
    if (rd_addr_in < `SSS_NUM_STATES) begin
      rd_data_out <= mem_reg[rd_addr_in];
    end else begin
      rd_data_out <= {`SSS_DEF_W{1'b0}};
    end
  end
endmodule // sss_state_mem

//--- rtl/sss_timer.v
// step counter that reports when a programmed count is reached
`timescale 1ns/100ps
module sss_timer (
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_n_in,
  // control
  input  wire        clear_in,
  input  wire        step_in,
  input  wire [15:0] limit_in,
  // result
  output wire        done_out
);
  reg [15:0] cnt_reg;

  // saturating count so a long wait never wraps back below the limit
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 16'h0000;
    end else if (clear_in) begin
      cnt_reg <= 16'h0000;
    end else if (step_in && (cnt_reg != 16'hffff)) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  assign done_out = (cnt_reg >= limit_in);
endmodule // sss_timer

//--- verification/sss_engine_props.sv
// port-level assertion checker for the supply sequencing state engine
`timescale 1ns/100ps
`include "sss_defines.vh"
module sss_engine_props #(
  parameter TO_STEP_CYC = 12500
) (
  // clock and reset
  input wire        sys_clk_in,
  input wire        rst_n_in,
  // register port
  input wire [7:0]  reg_addr_in,
  input wire        reg_rd_in,
  input wire [31:0] reg_rdata_out,
  // live status and engine state
  input wire [9:0]  uv_in,
  input wire [9:0]  ov_in,
  input wire [9:0]  lim_in,
  input wire [5:0]  state_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  // read data only stands in the answer cycle, so a stray value cannot be mistaken for data
  property p_rd_quiet;
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero outside answer");
  // status reads return the level present at the strobe
  property p_uv_live;
    reg_rd_in && reg_addr_in == `SSS_OFS_UV |=> reg_rdata_out == {22'h0, $past(uv_in)};
  endproperty
  a_uv_live: assert property (p_uv_live) else $error("undervoltage status read mismatch");
  property p_ov_live;
    reg_rd_in && reg_addr_in == `SSS_OFS_OV ##1 1'b1 |-> reg_rdata_out == {22'h0, $past(ov_in)};
  endproperty
  a_ov_live: assert property (p_ov_live) else $error("overvoltage status read mismatch");
  property p_lim_live;
    reg_rd_in && reg_addr_in == `SSS_OFS_LIM |-> ##1 reg_rdata_out[9:0] == $past(lim_in, 1);
  endproperty
  a_lim_live: assert property (p_lim_live) else $error("limit status read mismatch");
  // unused offsets answer zero
  property p_unmapped;
    reg_rd_in && reg_addr_in == 8'hfc |=> reg_rdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // low latch word holds five inputs only
  property p_flt_lo_width;
    reg_rd_in && reg_addr_in == `SSS_OFS_FLT_LO |=> reg_rdata_out[31:5] == 27'h0;
  endproperty
  a_flt_lo_width: assert property (p_flt_lo_width) else $error("fault latch word too wide");
  property p_cmd_width;
    reg_rd_in && reg_addr_in == `SSS_OFS_CMD |=> reg_rdata_out[31:2] == 30'h0;
  endproperty
  a_cmd_width: assert property (p_cmd_width) else $error("command readback too wide");
  // only 63 definitions exist
  property p_state_range;
    state_out != 6'h3f;
  endproperty
  a_state_range: assert property (p_state_range) else $error("state index out of range");
endmodule // sss_engine_props
bind sss_engine sss_engine_props #(.TO_STEP_CYC(TO_STEP_CYC)) i_sss_engine_props (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .uv_in(uv_in), .ov_in(ov_in), .lim_in(lim_in), .state_out(state_out));

//--- verification/sss_supply_model.sv
// model of the supply detectors, warning sources and digital inputs
`timescale 1ns/100ps
module sss_supply_model (
  // conditions set by the bench
  input  wire [9:0] fail_in,
  input  wire [9:0] over_in,
  input  wire [9:0] lim_in,
  input  wire       sec_in,
  input  wire [4:0] dig_in,
  // detector results toward the engine
  output wire [9:0] sfd_ok_out,
  output wire [9:0] uv_out,
  output wire [9:0] ov_out,
  output wire [9:0] lim_out,
  output wire       adc_warn_out,
  output wire       sec_warn_out,
  output wire [4:0] dig_out
);
  // a supply is okay only when neither under nor over its window
  assign sfd_ok_out   = ~(fail_in | over_in);
  assign uv_out       = fail_in;
  assign ov_out       = over_in;
  assign lim_out      = lim_in;
  // any converter limit trip raises the converter warning line
  assign adc_warn_out = |lim_in;
  assign sec_warn_out = sec_in;
  assign dig_out      = dig_in;
endmodule // sss_supply_model

//--- verification/sss_engine_bench.sv
// self-checking bench for the supply sequencing state engine
`timescale 1ns/100ps
`include "sss_defines.vh"
`define CHK(got, exp) begin cmp_count = cmp_count + 1; if ((got) !== (exp)) begin \
  fail_count = fail_count + 1; $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module sss_engine_bench;
  reg         sys_clk_in   = 1'b0;
  reg         rst_n_in     = 1'b0;
  reg  [7:0]  reg_addr_in  = 8'h00;
  reg  [31:0] reg_wdata_in = 32'h0;
  reg         reg_wr_in    = 1'b0;
  reg         reg_rd_in    = 1'b0;
  reg  [9:0]  fail         = 10'h001;
  reg  [9:0]  over         = 10'h000;
  reg  [9:0]  lim_set      = 10'h000;
  reg         sec_set      = 1'b0;
  reg  [4:0]  dig_set      = 5'h00;
  wire [31:0] reg_rdata_out;
  wire [9:0]  sfd_ok, uv, ov, lim, drv;
  wire [5:0]  state_out;
  wire        adc_warn, sec_warn;
  wire [4:0]  dig;
  reg  [31:0] q;
  reg  [9:0]  d1;
  integer     fail_count = 0, cmp_count = 0, cyc = 0, n, k;
  ////////////////////////////////////////
  sss_engine #(.TO_STEP_CYC(10)) i_sss_engine (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sfd_ok_in(sfd_ok), .uv_in(uv), .ov_in(ov), .lim_in(lim),
    .adc_limit_warn_in(adc_warn), .secondary_warn_in(sec_warn), .dual_function_input_in(dig),
    .programmable_driver_output_out(drv), .state_out(state_out));
  sss_supply_model i_sss_supply_model (.fail_in(fail), .over_in(over), .lim_in(lim_set), .sec_in(sec_set),
    .dig_in(dig_set), .sfd_ok_out(sfd_ok), .uv_out(uv), .ov_out(ov), .lim_out(lim),
    .adc_warn_out(adc_warn), .sec_warn_out(sec_warn), .dig_out(dig));
  // 125 MHz clock and a hang guard well above the expected run
  always #4 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end
  ////////////////////////////////////////
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // one-cycle strobes launched right after an edge
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] v);
    begin
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      #1 v = reg_rdata_out;
    end
  endtask
  function [79:0] mk(input [9:0] dv, input [4:0] ss, input sl, input [15:0] sd, input [11:0] to,
    input [15:0] mm, input lt, input mp, input [5:0] ns, input [5:0] nm, input [5:0] nt);
    mk = {nt, nm, ns, mp, lt, mm, to, sd, sl, ss, dv};
  endfunction
  task wdef(input [5:0] i, input [79:0] d);
    begin
      wr(`SSS_OFS_DEF_W0, d[31:0]);
      wr(`SSS_OFS_DEF_W1, d[63:32]);
      wr(`SSS_OFS_DEF_W2, {16'h0, d[79:64]});
      wr(`SSS_OFS_DEF_ADDR, {26'h0, i});
    end
  endtask
  // bounded wait for a given state index
  task wait_st(input [5:0] s, input integer lim_cyc);
    begin
      n = 0;
      while (state_out !== s && n < lim_cyc) begin
        @(posedge sys_clk_in);
        #1 n = n + 1;
      end
    end
  endtask
  ////////////////////////////////////////
  // select 5'h10 is never met, so those states leave only by monitor, timeout or jump
  task t_program;
    begin
      wdef(0, mk(10'h001, 5'd0, 1, 16'd4, 0, 16'h0, 0, 0, 1, 0, 0));
      wdef(1, mk(10'h002, 5'h10, 0, 0, 0, 16'h0002, 1, 0, 0, 2, 0));
      wdef(2, mk(10'h004, 5'h10, 0, 0, 12'd3, 16'h0, 0, 0, 0, 0, 3));
      wdef(3, mk(10'h008, 5'h10, 0, 0, 0, 16'h0010, 0, 0, 0, 4, 0));
      wdef(4, mk(10'h010, 5'h10, 0, 0, 0, 16'h0, 0, 0, 5, 0, 0));
      wdef(5, mk(10'h020, 5'h10, 0, 0, 0, 16'h8000, 0, 1, 0, 6, 0));
      wdef(6, mk(10'h040, 5'h10, 0, 0, 0, 16'h8000, 0, 1, 0, 7, 0));
      wdef(7, mk(10'h080, 5'd10, 1, 0, 0, 16'h0, 0, 0, 8, 0, 0));
      wdef(8, mk(10'h100, 5'd0, 0, 0, 0, 16'h0001, 0, 0, 11, 9, 0));
      wdef(9, mk(10'h200, 5'h10, 0, 0, 0, 16'h0, 0, 0, 0, 0, 0));
    end
  endtask
  // qualifying delay of four 10 us steps, restarted by a one-cycle drop
  task t_seq;
    begin
      wr(`SSS_OFS_CMD, 32'h2);
      repeat (4) @(posedge sys_clk_in);
      #1 `CHK(drv, 10'h001)
      @(posedge sys_clk_in);
      fail[0] <= 1'b0;
      repeat (1000) @(posedge sys_clk_in);
      fail[0] <= 1'b1;
      @(posedge sys_clk_in);
      fail[0] <= 1'b0;
      repeat (4900) @(posedge sys_clk_in);
      #1 `CHK(state_out, 6'd0)
      wait_st(1, 1400);
      `CHK(state_out, 6'd1)
      `CHK(drv, 10'h002)
    end
  endtask
  // monitor exit latches its input; timeout follows in the next state
  task t_mon;
    begin
      rd(`SSS_OFS_FLT_LO, q);
      `CHK(q, 32'h0)
      @(posedge sys_clk_in);
      fail[1] <= 1'b1;
      wait_st(2, 6);
      `CHK(state_out, 6'd2)
      rd(`SSS_OFS_FLT_LO, q);
      `CHK(q, 32'h2)
      fail[1] <= 1'b0;
      wait_st(3, 60);
      `CHK(state_out, 6'd3)
      `CHK(n >= 28, 1'b1)
    end
  endtask
  // latch disabled: monitor still exits, old bit kept, new bit not set
  task t_latch_off;
    begin
      @(posedge sys_clk_in);
      fail[4] <= 1'b1;
      wait_st(4, 6);
      `CHK(state_out, 6'd4)
      rd(`SSS_OFS_FLT_LO, q);
      `CHK(q, 32'h2)
      fail[4] <= 1'b0;
      wr(`SSS_OFS_CMD, 32'h1);
      wait_st(5, 10);
      `CHK(state_out, 6'd5)
    end
  endtask
  // each warning source alone trips the combined warning input
  task t_warn;
    begin
      @(posedge sys_clk_in);
      lim_set <= 10'h001;
      @(posedge sys_clk_in);
      lim_set <= 10'h000;
      wait_st(6, 6);
      `CHK(state_out, 6'd6)
      sec_set <= 1'b1;
      @(posedge sys_clk_in);
      sec_set <= 1'b0;
      wait_st(7, 6);
      `CHK(state_out, 6'd7)
    end
  endtask
  // digital input counts only once enabled; then simultaneous exits
  task t_dig_prio;
    begin
      @(posedge sys_clk_in);
      dig_set <= 5'h01;
      repeat (20) @(posedge sys_clk_in);
      #1 `CHK(state_out, 6'd7)
      wr(`SSS_OFS_DIG_EN, 32'h1);
      wait_st(8, 10);
      `CHK(state_out, 6'd8)
      fail[0] <= 1'b1;
      wait_st(9, 6);
      `CHK(state_out, 6'd9)
      `CHK(drv, 10'h200)
    end
  endtask
  // bus-driven and clock-driven outputs, then live status and unmapped reads
  task t_drv_status;
    begin
      wr(`SSS_OFS_DRV_BUS, 32'h1);
      wr(`SSS_OFS_DRV_SRC, 32'h9);
      repeat (3) @(posedge sys_clk_in);
      #1 `CHK(drv[0], 1'b1)
      k = 0;
      d1 = drv;
      repeat (1250) begin
        @(posedge sys_clk_in);
        #1 if (drv[1] !== d1[1]) k = k + 1;
        d1 = drv;
      end
      `CHK(k, 2)
      fail <= 10'h2aa;
      over <= 10'h155;
      lim_set <= 10'h3c0;
      rd(`SSS_OFS_UV, q);
      `CHK(q, 32'h2aa)
      rd(`SSS_OFS_OV, q);
      `CHK(q, 32'h155)
      rd(`SSS_OFS_LIM, q);
      `CHK(q, 32'h3c0)
      fail <= 10'h000;
      rd(`SSS_OFS_UV, q);
      `CHK(q, 32'h0)
      rd(8'hfc, q);
      `CHK(q, 32'h0)
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    #1 `CHK(state_out, 6'd0)
    `CHK(drv, 10'h000)
    t_program;
    t_seq;
    t_mon;
    t_latch_off;
    t_warn;
    t_dig_prio;
    t_drv_status;
    give_verdict;
  end
endmodule // sss_engine_bench
